/* File: inc/ccw_cfg.svh */
// constants of the clarke coefficient weighting block
// assumes one clock (mclk) and apb register access, 32-bit data
//
// Overview of operation
// - coarse ch1 scaled by coarse real coef 1
// - coarse ch2 scaled by coarse real coef 2
// - coarse ch3 scaled by coarse real coef 3
// - fine ch0 scaled by fine imag coef 0
// - fine ch1 scaled by fine imag coef 1
// - fine ch2 scaled by fine imag coef 2
// - fine ch3 scaled by fine imag coef 3
// - fine ch0 scaled by fine real coef 0
// - coefficients are signed q2.14 in bits 15:0
// - all register coefficients reset to zero
`ifndef CCW_CFG_SVH
`define CCW_CFG_SVH

// ************************************************************
// register indices (byte address is four times the index)
// ************************************************************
`define CCW_IDX_W      8
`define CCW_IDX_CRE1   8'h17
`define CCW_IDX_CRE2   8'h18
`define CCW_IDX_CRE3   8'h19
`define CCW_IDX_FIM0   8'h1a
`define CCW_IDX_FIM1   8'h1b
`define CCW_IDX_FIM2   8'h1c
`define CCW_IDX_FIM3   8'h1d
`define CCW_IDX_FRE0   8'h1e
`define CCW_NREG       8
`define CCW_SLOT_W     3

// ************************************************************
// fields, widths and reset values
// ************************************************************
`define CCW_COEF_W     16
`define CCW_COEF_RST   16'h0000
`define CCW_Q_FRAC     14
`define CCW_RD_PAD     16'h0000
`define CCW_LANES      2
`define CCW_LANE_W     8
`define CCW_CH_W       16
`define CCW_SUM_W      34
`define CCW_NSUM       3
`define CCW_SUM_CRE    0
`define CCW_SUM_FIM    1
`define CCW_SUM_FRE    2

`endif

/* File: inc/ccw_pkg.sv */
// types shared by the clarke coefficient weighting block
// assumes ccw_cfg.svh on the include path
`default_nettype none
`include "ccw_cfg.svh"

package ccw_pkg;

  typedef logic signed [`CCW_COEF_W-1:0] ccw_coef_type;
  typedef logic signed [`CCW_CH_W-1:0]   ccw_chan_type;
  typedef logic signed [`CCW_SUM_W-1:0]  ccw_sum_type;

  // one coefficient per filter/rectifier channel
  typedef struct packed {
    ccw_coef_type c3;
    ccw_coef_type c2;
    ccw_coef_type c1;
    ccw_coef_type c0;
  } ccw_coefset_type;

  // four filter/rectifier outputs of one receive block
  typedef struct packed {
    ccw_chan_type h3;
    ccw_chan_type h2;
    ccw_chan_type h1;
    ccw_chan_type h0;
  } ccw_chanset_type;

  // whole state of the top module
  typedef struct packed {
    logic [`CCW_NREG-1:0][`CCW_COEF_W-1:0] coef;
    logic [31:0]                           rdata;
    logic                                  res_valid;
    ccw_sum_type                           coarse_real;
    ccw_sum_type                           fine_imag;
    ccw_sum_type                           fine_real;
  } ccw_state_type;

endpackage

`default_nettype wire

/* File: hw/ccw_rst_sync.sv */
// reset release synchroniser
// assumes rst_n may rise at any time relative to mclk
`timescale 1ns/10ps
`default_nettype none

module ccw_rst_sync (
  input  wire logic mclk,    // system clock
  input  wire logic rst_n,   // raw asynchronous reset
  output var  logic rst_s_n  // reset with synchronous release
);

  logic meta_q;

  // ************************************************************
  // two stages: assert at once, release on the second edge
  // ************************************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q  <= 1'b0;
      rst_s_n <= 1'b0;
    end else begin
      meta_q  <= 1'b1;
      rst_s_n <= meta_q;
    end
  end

endmodule // ccw_rst_sync

`default_nettype wire

/* File: hw/ccw_mac.sv */
// four-term weighted sum of one receive block
// assumes operands stable for the cycle; purely combinational
`timescale 1ns/10ps
`default_nettype none

module ccw_mac (
  input  wire ccw_pkg::ccw_chanset_type chan, // channel outputs
  input  wire ccw_pkg::ccw_coefset_type coef, // q2.14 weights
  output var  ccw_pkg::ccw_sum_type     sum   // full-precision sum
);

  ccw_pkg::ccw_sum_type p0, p1, p2, p3;

  // ************************************************************
  // widen before multiplying so no product bit is lost
  // ************************************************************
  always_comb begin
    p0  = ccw_pkg::ccw_sum_type'(chan.h0) *
          ccw_pkg::ccw_sum_type'(coef.c0);
    p1  = ccw_pkg::ccw_sum_type'(chan.h1) *
          ccw_pkg::ccw_sum_type'(coef.c1);
    p2  = ccw_pkg::ccw_sum_type'(chan.h2) *
          ccw_pkg::ccw_sum_type'(coef.c2);
    p3  = ccw_pkg::ccw_sum_type'(chan.h3) *
          ccw_pkg::ccw_sum_type'(coef.c3);
    sum = p0 + p1 + p2 + p3; // two guard bits, cannot wrap
  end

endmodule // ccw_mac

`default_nettype wire

/* File: hw/ccw_top.sv */
// clarke coefficient weighting: apb coefficient file and the
// three weighted sums (coarse real, fine imaginary, fine real)
// assumes apb master on mclk; samples synchronous to mclk;
// coefficients outside this block arrive on plain ports
`timescale 1ns/10ps
`default_nettype none
`include "ccw_cfg.svh"

module ccw_top #(
  parameter int APB_AW = 12                   // apb address width
) (
  input  wire logic                   mclk,         // 10 mhz clock
  input  wire logic                   rst_n,        // async reset
  input  wire logic                   psel,         // apb select
  input  wire logic                   penable,      // apb enable
  input  wire logic                   pwrite,       // apb direction
  input  wire logic [APB_AW-1:0]      paddr,        // byte address
  input  wire logic [31:0]            pwdata,       // write data
  input  wire logic [3:0]             pstrb,        // byte strobes
  output var  logic [31:0]            prdata,       // read data
  output var  logic                   pready,       // always ready
  output var  logic                   pslverr,      // unmapped
  input  wire logic                   smp_valid,    // new samples
  input  wire ccw_pkg::ccw_chanset_type coarse_ch,  // coarse outs
  input  wire ccw_pkg::ccw_chanset_type fine_ch,    // fine outs
  input  wire ccw_pkg::ccw_coef_type  coarse_real_coef_0, // ext
  input  wire ccw_pkg::ccw_coef_type  fine_real_coef_1,   // ext
  input  wire ccw_pkg::ccw_coef_type  fine_real_coef_2,   // ext
  input  wire ccw_pkg::ccw_coef_type  fine_real_coef_3,   // ext
  output var  logic                   res_valid,    // sums updated
  output var  ccw_pkg::ccw_sum_type   coarse_real,  // coarse re
  output var  ccw_pkg::ccw_sum_type   fine_imag,    // fine im
  output var  ccw_pkg::ccw_sum_type   fine_real     // fine re
);

  // ************************************************************
  // declarations
  // ************************************************************
  logic                      rst_s_n;
  ccw_pkg::ccw_state_type    st_q, st_d;
  logic [`CCW_IDX_W-1:0]     word_idx;
  logic [`CCW_SLOT_W-1:0]    slot;
  logic                      hit;
  logic                      setup_ph;
  logic                      wr_acc;
  ccw_pkg::ccw_chanset_type  chan_sel [`CCW_NSUM];
  ccw_pkg::ccw_coefset_type  coef_sel [`CCW_NSUM];
  ccw_pkg::ccw_sum_type      sum_w    [`CCW_NSUM];

  // ************************************************************
  // reset release
  // ************************************************************
  ccw_rst_sync u_rst (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .rst_s_n (rst_s_n)
  );

  // ************************************************************
  // address decode
  // ************************************************************
  // misaligned or high addresses fall outside the map
  assign word_idx = paddr[`CCW_IDX_W+1:2];
  assign hit      = (paddr[1:0] == 2'h0) &&
                    (paddr[APB_AW-1:`CCW_IDX_W+2] == '0) &&
                    (word_idx >= `CCW_IDX_CRE1) &&
                    (word_idx <= `CCW_IDX_FRE0);
  assign slot     = `CCW_SLOT_W'(word_idx - `CCW_IDX_CRE1);
  assign setup_ph = psel && !penable;
  assign wr_acc   = psel && penable && pwrite && hit;

  // zero wait states; error only in the access phase
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;

  // ************************************************************
  // coefficient routing to the three sums
  // ************************************************************
  // coarse real: slot 0..2 weight channels 1..3
  always_comb begin
    chan_sel[`CCW_SUM_CRE]    = coarse_ch;
    coef_sel[`CCW_SUM_CRE].c0 = coarse_real_coef_0;
    coef_sel[`CCW_SUM_CRE].c1 = st_q.coef[0];
    coef_sel[`CCW_SUM_CRE].c2 = st_q.coef[1];
    coef_sel[`CCW_SUM_CRE].c3 = st_q.coef[2];
    chan_sel[`CCW_SUM_FIM]    = fine_ch;
    coef_sel[`CCW_SUM_FIM].c0 = st_q.coef[3];
    coef_sel[`CCW_SUM_FIM].c1 = st_q.coef[4];
    coef_sel[`CCW_SUM_FIM].c2 = st_q.coef[5];
    coef_sel[`CCW_SUM_FIM].c3 = st_q.coef[6];
    chan_sel[`CCW_SUM_FRE]    = fine_ch;
    coef_sel[`CCW_SUM_FRE].c0 = st_q.coef[7];
    coef_sel[`CCW_SUM_FRE].c1 = fine_real_coef_1;
    coef_sel[`CCW_SUM_FRE].c2 = fine_real_coef_2;
    coef_sel[`CCW_SUM_FRE].c3 = fine_real_coef_3;
  end

  // one multiply-accumulate per output
  for (genvar g = 0; g < `CCW_NSUM; g++) begin : g_mac
    ccw_mac u_mac (
      .chan (chan_sel[g]),
      .coef (coef_sel[g]),
      .sum  (sum_w[g])
    );
  end

  // ************************************************************
  // next state
  // ************************************************************
  // coefficient change lands at the access edge; a sample in
  // that same cycle still sees the old weights
  always_comb begin
    st_d           = st_q;
    st_d.res_valid = 1'b0;
    if (wr_acc) begin
      for (int l = 0; l < `CCW_LANES; l++) begin
        if (pstrb[l]) begin
          st_d.coef[slot][l*`CCW_LANE_W +: `CCW_LANE_W] =
            pwdata[l*`CCW_LANE_W +: `CCW_LANE_W];
        end
      end
    end
    // read data is fetched in setup so it is a flip-flop output
    if (setup_ph) begin
      if (hit && !pwrite) begin
        st_d.rdata = {`CCW_RD_PAD, st_q.coef[slot]};
      end else begin
        st_d.rdata = '0;
      end
    end
    if (smp_valid) begin
      st_d.res_valid   = 1'b1;
      st_d.coarse_real = sum_w[`CCW_SUM_CRE];
      st_d.fine_imag   = sum_w[`CCW_SUM_FIM];
      st_d.fine_real   = sum_w[`CCW_SUM_FRE];
    end
  end

  // ************************************************************
  // state register
  // ************************************************************
  // uncalibrated register coefficients contribute nothing until written; the four port coefficients are not reset
  always_ff @(posedge mclk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      st_q <= '0; // every coefficient 0x0000
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata      = st_q.rdata;
  assign res_valid   = st_q.res_valid;
  assign coarse_real = st_q.coarse_real;
  assign fine_imag   = st_q.fine_imag;
  assign fine_real   = st_q.fine_real;

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_s_n);

  // independent product for checking, widened the same way
  function automatic ccw_pkg::ccw_sum_type mul(
    input ccw_pkg::ccw_chan_type a,
    input ccw_pkg::ccw_coef_type b
  );
    mul = ccw_pkg::ccw_sum_type'(a) * ccw_pkg::ccw_sum_type'(b);
  endfunction

  logic cz_123, fz_123, fz_023;
  assign cz_123 = (coarse_ch.h0 == '0) && (coarse_ch.h2 == '0) &&
                  (coarse_ch.h3 == '0);
  assign fz_123 = (fine_ch.h1 == '0) && (fine_ch.h2 == '0) &&
                  (fine_ch.h3 == '0);
  assign fz_023 = (fine_ch.h0 == '0) && (fine_ch.h2 == '0) &&
                  (fine_ch.h3 == '0);

  property p_cre1;
    smp_valid && cz_123 |=>
      coarse_real == mul($past(coarse_ch.h1), $past(st_q.coef[0]));
  endproperty
  a_cre1: assert property (p_cre1)
    else $error("coarse real 1 weighting wrong");

  property p_cre2;
    smp_valid && (coarse_ch.h0 == '0) && (coarse_ch.h1 == '0) &&
    (coarse_ch.h3 == '0) |=>
      coarse_real == mul($past(coarse_ch.h2), $past(st_q.coef[1]));
  endproperty
  a_cre2: assert property (p_cre2)
    else $error("coarse real 2 weighting wrong");

  property p_cre3;
    smp_valid ##0 (coarse_ch.h0 == '0 && coarse_ch.h1 == '0 &&
    coarse_ch.h2 == '0) |=> res_valid &&
      coarse_real == mul($past(coarse_ch.h3), $past(st_q.coef[2]));
  endproperty
  a_cre3: assert property (p_cre3)
    else $error("coarse real 3 weighting wrong");

  property p_fim0;
    smp_valid && fz_123 |=>
      fine_imag == mul($past(fine_ch.h0), $past(st_q.coef[3]));
  endproperty
  a_fim0: assert property (p_fim0)
    else $error("fine imag 0 weighting wrong");

  property p_fim1;
    smp_valid && fz_023 |=>
      fine_imag == mul($past(fine_ch.h1), $past(st_q.coef[4]));
  endproperty
  a_fim1: assert property (p_fim1)
    else $error("fine imag 1 weighting wrong");

  property p_fim2;
    smp_valid && (fine_ch.h0 == '0) && (fine_ch.h1 == '0) &&
    (fine_ch.h3 == '0) |=>
      fine_imag == mul($past(fine_ch.h2), $past(st_q.coef[5]));
  endproperty
  a_fim2: assert property (p_fim2)
    else $error("fine imag 2 weighting wrong");

  property p_fim3;
    smp_valid && (fine_ch.h0 == '0) && (fine_ch.h1 == '0) &&
    (fine_ch.h2 == '0) |=>
      fine_imag == mul($past(fine_ch.h3), $past(st_q.coef[6]));
  endproperty
  a_fim3: assert property (p_fim3)
    else $error("fine imag 3 weighting wrong");

  property p_fre0;
    smp_valid && fz_123 |=>
      fine_real == mul($past(fine_ch.h0), $past(st_q.coef[7]));
  endproperty
  a_fre0: assert property (p_fre0)
    else $error("fine real 0 weighting wrong");

  // full-strobe write, one idle cycle, then a read of the same
  // word: readback holds the written value, upper half zero
  property p_wr_rd;
    (wr_acc && pstrb[1:0] == 2'h3) ##2
      (setup_ph && hit && !pwrite && slot == $past(slot, 2))
    |=> prdata == {`CCW_RD_PAD, $past(pwdata[`CCW_COEF_W-1:0], 3)};
  endproperty
  a_wr_rd: assert property (p_wr_rd)
    else $error("coefficient readback wrong");

  property p_rst_zero;
    $rose(rst_s_n) |-> (st_q.coef == '0) && !res_valid;
  endproperty
  a_rst_zero: assert property (
    @(posedge mclk) disable iff (1'b0) p_rst_zero)
    else $error("coefficients not zero after reset");

  property p_sum_full;
    smp_valid |=> fine_real ==
      mul($past(fine_ch.h0), $past(st_q.coef[7])) +
      mul($past(fine_ch.h1), $past(fine_real_coef_1)) +
      mul($past(fine_ch.h2), $past(fine_real_coef_2)) +
      mul($past(fine_ch.h3), $past(fine_real_coef_3));
  endproperty
  a_sum_full: assert property (p_sum_full)
    else $error("fine real sum wrong");

  property p_hold;
    !smp_valid |=> !res_valid && $stable(coarse_real) &&
      $stable(fine_imag);
  endproperty
  a_hold: assert property (p_hold)
    else $error("result changed without a sample");

  property p_unmapped;
    psel && penable && !hit && !pwrite |-> pslverr && prdata == '0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not refused");

  // ************************************************************
  // coverage of the main scenarios
  // ************************************************************
  property p_cv_write;
    wr_acc && pstrb[1:0] == 2'h3;
  endproperty
  c_cv_write: cover property (p_cv_write);

  property p_cv_read_back;
    wr_acc ##2 setup_ph && hit && !pwrite;
  endproperty
  c_cv_read_back: cover property (p_cv_read_back);

  property p_cv_neg_sum;
    smp_valid ##1 fine_imag[`CCW_SUM_W-1];
  endproperty
  c_cv_neg_sum: cover property (p_cv_neg_sum);

  property p_cv_unmapped;
    pslverr;
  endproperty
  c_cv_unmapped: cover property (p_cv_unmapped);

endmodule // ccw_top

`default_nettype wire

/* File: verif/ccw_top_tb.sv */
// self-checking bench of the clarke coefficient weighting block
// assumes ccw_pkg compiled first and ccw_cfg.svh on the include path
`timescale 1ns/10ps
`default_nettype none
`include "ccw_cfg.svh"

module ccw_top_tb;

  // ************************************************************
  // stimulus, observation and bookkeeping
  // ************************************************************
  logic                     mclk;
  logic                     rst_n;
  logic                     psel;
  logic                     penable;
  logic                     pwrite;
  logic [11:0]              paddr;
  logic [31:0]              pwdata;
  logic [3:0]               pstrb;
  logic [31:0]              prdata;
  logic                     pready;
  logic                     pslverr;
  logic                     smp_valid;
  ccw_pkg::ccw_chanset_type coarse_ch;
  ccw_pkg::ccw_chanset_type fine_ch;
  ccw_pkg::ccw_coef_type    coarse_real_coef_0;
  ccw_pkg::ccw_coef_type    fine_real_coef_1;
  ccw_pkg::ccw_coef_type    fine_real_coef_2;
  ccw_pkg::ccw_coef_type    fine_real_coef_3;
  logic                     res_valid;
  ccw_pkg::ccw_sum_type     coarse_real;
  ccw_pkg::ccw_sum_type     fine_imag;
  ccw_pkg::ccw_sum_type     fine_real;
  int                       fail_count;
  int                       n_tests;
  ccw_pkg::ccw_coef_type    k [`CCW_NREG]; // mirror of the register file

  ccw_top #(.APB_AW(12)) dut (
    .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .smp_valid(smp_valid), .coarse_ch(coarse_ch), .fine_ch(fine_ch),
    .coarse_real_coef_0(coarse_real_coef_0),
    .fine_real_coef_1(fine_real_coef_1),
    .fine_real_coef_2(fine_real_coef_2),
    .fine_real_coef_3(fine_real_coef_3),
    .res_valid(res_valid), .coarse_real(coarse_real),
    .fine_imag(fine_imag), .fine_real(fine_real)
  );

  // 100 ns period
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // ************************************************************
  // reporting
  // ************************************************************
  task automatic complete_run;
    if (fail_count == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_sum(input ccw_pkg::ccw_sum_type got,
                           input ccw_pkg::ccw_sum_type exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // ************************************************************
  // bus and reset helpers
  // ************************************************************
  function automatic logic [11:0] reg_addr(input int i);
    return 12'((`CCW_IDX_CRE1 + i) * 4);
  endfunction

  // one apb transfer; request held until pready is seen high
  task automatic apb_xfer(input logic wr, input logic [11:0] a,
                          input logic [31:0] wd, input logic [3:0] st,
                          output logic [31:0] rd, output logic err);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    pstrb <= st;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      fail_count++;
      complete_run();
    end
  endtask

  // reset asserted for 8 cycles; 3 edges pass before the first request
  task automatic do_reset;
    rst_n <= 1'b0;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    foreach (k[i]) k[i] = 16'h0000;
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_read_all;
    logic [31:0] rd;
    logic        err;
    foreach (k[i]) begin
      apb_xfer(1'b0, reg_addr(i), 32'h0, 4'h0, rd, err);
      check_word(rd, {16'h0000, k[i]});
      check_word(32'(err), 32'h0);
    end
  endtask

  // upper data half is junk on purpose: only bits 15:0 may land
  task automatic t_write_all;
    logic [31:0] rd;
    logic        err;
    foreach (k[i]) begin
      k[i] = 16'(16'h9001 + 16'h1111 * i);
      apb_xfer(1'b1, reg_addr(i), {16'hdead, k[i]}, 4'hf, rd, err);
      apb_xfer(1'b0, reg_addr(i), 32'h0, 4'h0, rd, err);
      check_word(rd, {16'h0000, k[i]});
    end
  endtask

  // one channel at a time, so each weight is seen on its own
  task automatic t_single;
    ccw_pkg::ccw_chanset_type v;
    for (int j = 0; j < 4; j++) begin
      v = '0;
      v[16*j +: 16] = 16'hc3a5;
      t_sample(v, v);
    end
  endtask

  // single low-byte strobe keeps the high byte
  task automatic t_strobe;
    logic [31:0] rd;
    logic        err;
    apb_xfer(1'b1, reg_addr(3), 32'h0000_5a5a, 4'h1, rd, err);
    k[3] = {k[3][15:8], 8'h5a};
    apb_xfer(1'b0, reg_addr(3), 32'h0, 4'h0, rd, err);
    check_word(rd, {16'h0000, k[3]});
  endtask

  // neighbours, misaligned and out-of-range places are refused
  task automatic t_unmapped;
    logic [11:0] bad [4];
    logic [31:0] rd;
    logic        err;
    bad = '{12'h058, 12'h07c, 12'h05d, 12'h400};
    foreach (bad[i]) begin
      apb_xfer(1'b1, bad[i], 32'h0000_ffff, 4'hf, rd, err);
      check_word(32'(err), 32'h1);
      apb_xfer(1'b0, bad[i], 32'h0, 4'h0, rd, err);
      check_word(32'(err), 32'h1);
      check_word(rd, 32'h0);
    end
  endtask

  // one sample; the sums are worked out here in full precision
  task automatic t_sample(input ccw_pkg::ccw_chanset_type c,
                          input ccw_pkg::ccw_chanset_type f);
    ccw_pkg::ccw_sum_type e_cr;
    ccw_pkg::ccw_sum_type e_fi;
    ccw_pkg::ccw_sum_type e_fr;
    e_cr = c.h0 * coarse_real_coef_0 + c.h1 * k[0] + c.h2 * k[1]
         + c.h3 * k[2];
    e_fi = f.h0 * k[3] + f.h1 * k[4] + f.h2 * k[5] + f.h3 * k[6];
    e_fr = f.h0 * k[7] + f.h1 * fine_real_coef_1
         + f.h2 * fine_real_coef_2 + f.h3 * fine_real_coef_3;
    @(posedge mclk);
    smp_valid <= 1'b1;
    coarse_ch <= c;
    fine_ch <= f;
    @(posedge mclk);
    smp_valid <= 1'b0;
    @(negedge mclk);
    check_word(32'(res_valid), 32'h1);
    check_sum(coarse_real, e_cr);
    check_sum(fine_imag, e_fi);
    check_sum(fine_real, e_fr);
    @(negedge mclk);
    check_word(32'(res_valid), 32'h0);
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    fail_count = 0;
    n_tests = 0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h0;
    smp_valid = 1'b0;
    coarse_ch = '0;
    fine_ch = '0;
    coarse_real_coef_0 = 16'h2000;
    fine_real_coef_1 = 16'hc000;
    fine_real_coef_2 = 16'h4000;
    fine_real_coef_3 = 16'h7fff;
    do_reset();
    t_read_all();
    t_write_all();
    t_read_all();
    t_strobe();
    t_unmapped();
    t_read_all();
    t_sample({16'h0004, 16'hfffd, 16'h0102, 16'h7fff},
             {16'h8000, 16'h0011, 16'hff00, 16'h0203});
    t_sample({16'h8000, 16'h8000, 16'h8000, 16'h8000},
             {16'h7fff, 16'h8000, 16'h7fff, 16'h8000});
    t_single();
    // mid-run reset is raised on a rising edge like every input
    @(posedge mclk);
    do_reset();
    t_read_all();
    t_sample({16'h1234, 16'h5678, 16'h9abc, 16'h4000},
             {16'h1111, 16'h2222, 16'h3333, 16'h4444});
    complete_run();
  end

endmodule // ccw_top_tb

`default_nettype wire
